//--- logic/iqr_defs.vh
`ifndef IQR_DEFS_VH
`define IQR_DEFS_VH
`define IQR_OFF_MASK        8'h5c
`define IQR_OFF_PROBE       8'h64
`define IQR_OFF_LEVELS      8'h68
`define IQR_OFF_RXSETUP     8'h6c
`define IQR_OFF_STATUS      8'h58
`define IQR_MASK_WRITABLE   32'h83bfefff
`define IQR_MASK_RESET      32'h00000000
`define IQR_PROBE_VALUE     32'h87654321
`define IQR_LEVELS_RESET    32'h48000000
`define IQR_RXSETUP_RESET   32'h00000000
`define IQR_RXSETUP_RW      32'hcfff1f00
`define IQR_BIT_RX_DMA      5'h14
`define IQR_BIT_TX_AVAIL    5'h09
`define IQR_BIT_TX_STLVL    5'h07
`define IQR_BIT_RX_DLVL     5'h05
`define IQR_BIT_RX_STLVL    5'h03
`define IQR_FLD_TXAV_HI     31
`define IQR_FLD_TXAV_LO     24
`define IQR_FLD_TXST_HI     23
`define IQR_FLD_TXST_LO     16
`define IQR_FLD_RXAV_HI     15
`define IQR_FLD_RXAV_LO     8
`define IQR_FLD_RXST_HI     7
`define IQR_FLD_RXST_LO     0
`define IQR_FLD_ALIGN_HI    31
`define IQR_FLD_ALIGN_LO    30
`define IQR_FLD_DMA_HI      27
`define IQR_FLD_DMA_LO      16
`define IQR_BIT_PURGE       15
`define IQR_FLD_OFF_HI      12
`define IQR_FLD_OFF_LO      8
`define IQR_ALIGN_4         2'h0
`define IQR_ALIGN_16        2'h1
`define IQR_ALIGN_32        2'h2
`endif

//--- logic/iqr_level_cmp.v
`timescale 1ns/1ps
`include "iqr_defs.vh"
module iqr_level_cmp #(
  parameter W = 8
) (
  // levels and thresholds
  input  wire [W-1:0] tx_free_blocks,
  input  wire [W-1:0] tx_stat_used,
  input  wire [W-1:0] rx_free_blocks,
  input  wire [W-1:0] rx_stat_used,
  input  wire [31:0]  thresholds,
  // level events
  output wire         tx_space_avail_event,
  output wire         tx_status_level_event,
  output wire         rx_data_level_event,
  output wire         rx_status_level_event
);
  assign tx_space_avail_event  = tx_free_blocks > thresholds[`IQR_FLD_TXAV_HI:`IQR_FLD_TXAV_LO];
  assign tx_status_level_event = tx_stat_used > thresholds[`IQR_FLD_TXST_HI:`IQR_FLD_TXST_LO];
  assign rx_data_level_event   = rx_free_blocks < thresholds[`IQR_FLD_RXAV_HI:`IQR_FLD_RXAV_LO];
  assign rx_status_level_event = rx_stat_used > thresholds[`IQR_FLD_RXST_HI:`IQR_FLD_RXST_LO];
endmodule // iqr_level_cmp

//--- logic/iqr_rx_pad.v
`timescale 1ns/1ps
`include "iqr_defs.vh"
module iqr_rx_pad (
  // alignment and buffer position
  input  wire [1:0] align_sel,
  input  wire [4:0] byte_count_mod,
  // padding dwords to append after last transfer
  output reg  [2:0] pad_dwords
);
  reg [4:0] used_dw;
  always @* begin
    used_dw    = {2'h0, byte_count_mod[4:2]} + {4'h0, |byte_count_mod[1:0]};
    pad_dwords = 3'h0;
    case (align_sel)
      `IQR_ALIGN_4: pad_dwords = 3'h0;
      `IQR_ALIGN_16: pad_dwords = (used_dw[1:0] == 2'h0) ? 3'h0 : 3'h4 - {1'b0, used_dw[1:0]};
      `IQR_ALIGN_32: pad_dwords = (used_dw[2:0] == 3'h0) ? 3'h0 : 3'h0 - used_dw[2:0];
      default: pad_dwords = 3'h0;
    endcase
  end
endmodule // iqr_rx_pad

//--- logic/iqr_config_regs.v
`timescale 1ns/1ps
`include "iqr_defs.vh"
module iqr_config_regs #(
  parameter LW = 8
) (
  // clock and reset
  input  wire          clk_sys,
  input  wire          resetn,
  // register port
  input  wire [7:0]    reg_addr,
  input  wire          reg_wr,
  input  wire          reg_rd,
  input  wire [31:0]   reg_wdata,
  output reg  [31:0]   reg_rdata,
  // interrupt sources, excluding rx dma and level events
  input  wire [31:0]   irq_source_in,
  output wire          irq_out,
  // fifo levels
  input  wire [LW-1:0] tx_free_blocks,
  input  wire [LW-1:0] tx_stat_used,
  input  wire [LW-1:0] rx_free_blocks,
  input  wire [LW-1:0] rx_stat_used,
  // receive data path
  input  wire          rx_dword_read,
  input  wire [4:0]    rx_last_bytes,
  output reg           rx_purge_pulse,
  output reg  [4:0]    rx_start_offset,
  output reg  [1:0]    rx_end_align,
  output reg  [2:0]    rx_pad_dwords,
  output reg  [11:0]   rx_dword_countdown
);
  reg  [31:0] irq_source_mask_reg;
  reg  [31:0] queue_level_thresholds_reg;
  reg  [31:0] irq_status_flags_reg;
  reg  [31:0] irq_status_flags_next;
  reg         dma_armed_reg;
  wire        tx_space_avail_event;
  wire        tx_status_level_event;
  wire        rx_data_level_event;
  wire        rx_status_level_event;
  wire [2:0]  pad_calc;
  wire        wr_mask;
  wire        wr_levels;
  wire        wr_rx;
  wire        wr_status;
  wire        dma_done;
  assign wr_mask   = reg_wr && (reg_addr == `IQR_OFF_MASK);
  assign wr_levels = reg_wr && (reg_addr == `IQR_OFF_LEVELS);
  assign wr_rx     = reg_wr && (reg_addr == `IQR_OFF_RXSETUP);
  assign wr_status = reg_wr && (reg_addr == `IQR_OFF_STATUS);
  // a rewrite of the count abandons the old amount, so no interrupt from it
  assign dma_done  = dma_armed_reg && rx_dword_read && !wr_rx && (rx_dword_countdown == 12'h001);

  iqr_level_cmp #(.W(LW)) u_cmp (
    .tx_free_blocks        (tx_free_blocks),
    .tx_stat_used          (tx_stat_used),
    .rx_free_blocks        (rx_free_blocks),
    .rx_stat_used          (rx_stat_used),
    .thresholds            (queue_level_thresholds_reg),
    .tx_space_avail_event  (tx_space_avail_event),
    .tx_status_level_event (tx_status_level_event),
    .rx_data_level_event   (rx_data_level_event),
    .rx_status_level_event (rx_status_level_event)
  );

  iqr_rx_pad u_pad (
    .align_sel      (rx_end_align),
    .byte_count_mod (rx_last_bytes),
    .pad_dwords     (pad_calc)
  );

  // status: set wins over write-one-to-clear
  always @* begin
    irq_status_flags_next = irq_status_flags_reg;
    if (wr_status)
      irq_status_flags_next = irq_status_flags_reg & ~reg_wdata;
    irq_status_flags_next = irq_status_flags_next | irq_source_in;
    irq_status_flags_next[`IQR_BIT_TX_AVAIL] = tx_space_avail_event | irq_status_flags_next[`IQR_BIT_TX_AVAIL];
    irq_status_flags_next[`IQR_BIT_TX_STLVL] = tx_status_level_event | irq_status_flags_next[`IQR_BIT_TX_STLVL];
    irq_status_flags_next[`IQR_BIT_RX_DLVL]  = rx_data_level_event | irq_status_flags_next[`IQR_BIT_RX_DLVL];
    irq_status_flags_next[`IQR_BIT_RX_STLVL] = rx_status_level_event | irq_status_flags_next[`IQR_BIT_RX_STLVL];
    irq_status_flags_next[`IQR_BIT_RX_DMA]   = dma_done | irq_status_flags_next[`IQR_BIT_RX_DMA];
    irq_status_flags_next = irq_status_flags_next & `IQR_MASK_WRITABLE;
  end

  assign irq_out = |(irq_status_flags_reg & irq_source_mask_reg);

  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      irq_source_mask_reg        <= `IQR_MASK_RESET;
      queue_level_thresholds_reg <= `IQR_LEVELS_RESET;
      irq_status_flags_reg       <= 32'h00000000;
      rx_end_align               <= 2'h0;
      rx_start_offset            <= 5'h00;
      rx_dword_countdown         <= 12'h000;
      dma_armed_reg              <= 1'b0;
      rx_purge_pulse             <= 1'b0;
      rx_pad_dwords              <= 3'h0;
    end else begin
      irq_status_flags_reg <= irq_status_flags_next;
      rx_pad_dwords        <= pad_calc;
      rx_purge_pulse       <= wr_rx && reg_wdata[`IQR_BIT_PURGE];
      if (wr_mask)
        irq_source_mask_reg <= reg_wdata & `IQR_MASK_WRITABLE;
      if (wr_levels)
        queue_level_thresholds_reg <= reg_wdata;
      if (wr_rx) begin
        rx_end_align       <= reg_wdata[`IQR_FLD_ALIGN_HI:`IQR_FLD_ALIGN_LO];
        rx_start_offset    <= reg_wdata[`IQR_FLD_OFF_HI:`IQR_FLD_OFF_LO];
        rx_dword_countdown <= reg_wdata[`IQR_FLD_DMA_HI:`IQR_FLD_DMA_LO];
        dma_armed_reg      <= |reg_wdata[`IQR_FLD_DMA_HI:`IQR_FLD_DMA_LO];
      end else if (rx_dword_read && dma_armed_reg) begin
        rx_dword_countdown <= rx_dword_countdown - 12'h001;
        if (rx_dword_countdown == 12'h001)
          dma_armed_reg <= 1'b0;
      end
    end
  end

  // read mux, unmapped addresses read zero
  always @* begin
    reg_rdata = 32'h00000000;
    if (reg_rd) begin
      case (reg_addr)
        `IQR_OFF_MASK:    reg_rdata = irq_source_mask_reg;
        `IQR_OFF_PROBE:   reg_rdata = `IQR_PROBE_VALUE;
        `IQR_OFF_LEVELS:  reg_rdata = queue_level_thresholds_reg;
        `IQR_OFF_RXSETUP: reg_rdata = {rx_end_align, 2'h0, rx_dword_countdown, 3'h0, rx_start_offset, 8'h00};
        `IQR_OFF_STATUS:  reg_rdata = irq_status_flags_reg;
        default:          reg_rdata = 32'h00000000;
      endcase
    end
  end
endmodule // iqr_config_regs

//--- verification/iqr_config_props.sv
`timescale 1ns/1ps
module iqr_config_props (
  // watched ports
  input wire        clk_sys,
  input wire        resetn,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire        irq_out,
  input wire        rx_dword_read,
  input wire        rx_purge_pulse,
  input wire [4:0]  rx_start_offset,
  input wire [1:0]  rx_end_align,
  input wire [11:0] rx_dword_countdown
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire cw = reg_wr && reg_addr == 8'h6c;
  a_purge_pulse: assert property (cw && reg_wdata[15] |=> rx_purge_pulse)
    else $error("purge pulse missing");
  a_purge_cause: assert property (rx_purge_pulse |-> $past(cw && reg_wdata[15]))
    else $error("stray purge pulse");
  a_probe_read: assert property (reg_rd && reg_addr == 8'h64 |-> reg_rdata == 32'h87654321)
    else $error("probe value wrong");
  a_mask_rsvd: assert property (reg_rd && reg_addr == 8'h5c |-> (reg_rdata & 32'h7c401000) == 32'h0)
    else $error("reserved mask bits set");
  a_irq_quiet: assert property (reg_wr && reg_addr == 8'h5c && reg_wdata == 32'h0 |=> !irq_out)
    else $error("irq with empty mask");
  a_count_dec: assert property (rx_dword_read && rx_dword_countdown != 12'h0 && !cw |=>
    rx_dword_countdown == $past(rx_dword_countdown) - 12'h1) else $error("countdown not decremented");
  a_count_load: assert property (cw && !rx_dword_read |=> rx_dword_countdown == $past(reg_wdata[27:16]))
    else $error("countdown not loaded");
  a_offset_load: assert property (cw |=> rx_start_offset == $past(reg_wdata[12:8]))
    else $error("offset not loaded");
  a_align_load: assert property (cw |=> rx_end_align == $past(reg_wdata[31:30]))
    else $error("alignment not loaded");
endmodule // iqr_config_props
bind iqr_config_regs iqr_config_props u_props (
  .clk_sys            (clk_sys),
  .resetn             (resetn),
  .reg_addr           (reg_addr),
  .reg_wr             (reg_wr),
  .reg_rd             (reg_rd),
  .reg_wdata          (reg_wdata),
  .reg_rdata          (reg_rdata),
  .irq_out            (irq_out),
  .rx_dword_read      (rx_dword_read),
  .rx_purge_pulse     (rx_purge_pulse),
  .rx_start_offset    (rx_start_offset),
  .rx_end_align       (rx_end_align),
  .rx_dword_countdown (rx_dword_countdown)
);

//--- verification/iqr_host_bfm.sv
`timescale 1ns/1ps
module iqr_host_bfm (
  // host bus
  input  wire         clk_sys,
  input  wire  [31:0] reg_rdata,
  output logic [7:0]  reg_addr = 8'h00,
  output logic        reg_wr = 1'b0,
  output logic        reg_rd = 1'b0,
  output logic [31:0] reg_wdata = 32'h0
);
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk_sys);
    reg_wr = 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge clk_sys);
    d = reg_rdata;
    @(negedge clk_sys);
    reg_rd = 1'b0;
  endtask
endmodule // iqr_host_bfm

//--- verification/iqr_config_regs_tb.sv
`timescale 1ns/1ps
module iqr_config_regs_tb;
  logic        clk_sys = 1'b0;
  logic        resetn = 1'b0;
  logic [31:0] irq_source_in = 32'h0;
  logic [7:0]  tx_free_blocks = 8'h0, tx_stat_used = 8'h0, rx_free_blocks = 8'h0, rx_stat_used = 8'h0;
  logic        rx_dword_read = 1'b0;
  logic [4:0]  rx_last_bytes = 5'h0;
  wire  [7:0]  reg_addr;
  wire         reg_wr, reg_rd, irq_out, rx_purge_pulse;
  wire  [31:0] reg_wdata, reg_rdata;
  wire  [4:0]  rx_start_offset;
  wire  [1:0]  rx_end_align;
  wire  [2:0]  rx_pad_dwords;
  wire  [11:0] rx_dword_countdown;
  int          errors = 0, num_checks = 0, cycles = 0;
  iqr_config_regs u_dut (
    .clk_sys            (clk_sys),
    .resetn             (resetn),
    .reg_addr           (reg_addr),
    .reg_wr             (reg_wr),
    .reg_rd             (reg_rd),
    .reg_wdata          (reg_wdata),
    .reg_rdata          (reg_rdata),
    .irq_source_in      (irq_source_in),
    .irq_out            (irq_out),
    .tx_free_blocks     (tx_free_blocks),
    .tx_stat_used       (tx_stat_used),
    .rx_free_blocks     (rx_free_blocks),
    .rx_stat_used       (rx_stat_used),
    .rx_dword_read      (rx_dword_read),
    .rx_last_bytes      (rx_last_bytes),
    .rx_purge_pulse     (rx_purge_pulse),
    .rx_start_offset    (rx_start_offset),
    .rx_end_align       (rx_end_align),
    .rx_pad_dwords      (rx_pad_dwords),
    .rx_dword_countdown (rx_dword_countdown)
  );
  iqr_host_bfm u_host (
    .clk_sys   (clk_sys),
    .reg_rdata (reg_rdata),
    .reg_addr  (reg_addr),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd),
    .reg_wdata (reg_wdata)
  );
  initial forever #20 clk_sys = ~clk_sys;
  task summarize;
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] e, input string n);
    logic [31:0] d;
    u_host.rd(a, d);
    chk(n, e, d);
  endtask
  task t_reset;
    rdchk(8'h5c, 32'h0, "mask");
    rdchk(8'h64, 32'h87654321, "probe");
    rdchk(8'h68, 32'h48000000, "levels");
    rdchk(8'h6c, 32'h0, "rxsetup");
  endtask
  task t_mask;
    u_host.wr(8'h5c, 32'hffffffff);
    rdchk(8'h5c, 32'h83bfefff, "mask rw");
    u_host.wr(8'h64, 32'h0);
    rdchk(8'h64, 32'h87654321, "probe ro");
    u_host.wr(8'h5c, 32'h0);
  endtask
  task t_irq;
    irq_source_in = 32'h80000000;
    @(negedge clk_sys);
    irq_source_in = 32'h0;
    chk("irq masked", 32'h0, irq_out);
    rdchk(8'h58, 32'h80000000, "status");
    u_host.wr(8'h5c, 32'h80000000);
    chk("irq on", 32'h1, irq_out);
    u_host.wr(8'h58, 32'h80000000);
    chk("irq clr", 32'h0, irq_out);
  endtask
  task t_levels;
    {tx_free_blocks, tx_stat_used, rx_free_blocks, rx_stat_used} = 32'h10101010;
    u_host.wr(8'h68, 32'h10101010);
    u_host.wr(8'h58, 32'hffffffff);
    rdchk(8'h58, 32'h0, "level edge");
    {tx_free_blocks, tx_stat_used, rx_free_blocks, rx_stat_used} = 32'h11110f11;
    rdchk(8'h58, 32'h2a8, "level over");
    {tx_free_blocks, tx_stat_used, rx_free_blocks, rx_stat_used} = 32'h0;
    u_host.wr(8'h68, 32'h0);
    u_host.wr(8'h58, 32'hffffffff);
  endtask
  task pulse(input int n);
    rx_dword_read = 1'b1;
    repeat (n) @(negedge clk_sys);
    rx_dword_read = 1'b0;
    @(negedge clk_sys);
  endtask
  task t_rx;
    u_host.wr(8'h5c, 32'h00100000);
    u_host.wr(8'h6c, 32'h00008000);
    chk("purge", 32'h1, rx_purge_pulse);
    rdchk(8'h6c, 32'h0, "purge reads zero");
    u_host.wr(8'h6c, 32'h80031f00);
    rdchk(8'h6c, 32'h80031f00, "rx setup");
    chk("offset", 32'h1f, rx_start_offset);
    chk("align", 32'h2, rx_end_align);
    pulse(1);
    chk("count", 32'h2, rx_dword_countdown);
    u_host.wr(8'h6c, 32'h80021f00);
    pulse(2);
    chk("count end", 32'h0, rx_dword_countdown);
    chk("dma irq", 32'h1, irq_out);
  endtask
  task t_pad;
    rx_last_bytes = 5'h4;
    for (int i = 0; i < 4; i++) begin
      u_host.wr(8'h6c, {i[1:0], 30'h0});
      @(negedge clk_sys);
      chk("pad", (i == 1) ? 3 : (i == 2) ? 7 : 0, rx_pad_dwords);
    end
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 5000) begin
      errors++;
      summarize();
    end
  end
  initial begin
    repeat (8) @(negedge clk_sys);
    resetn = 1'b1;
    t_reset();
    t_mask();
    t_irq();
    t_levels();
    t_rx();
    t_pad();
    summarize();
  end
endmodule // iqr_config_regs_tb
